// ### core/poc_pkg.sv
// Constants, types and decode helpers for offset calibration control
// Notes on behaviour
// - Target code 0..7 gives 3..511; reset 2
// - Calibration aims result at target; offset may go negative
// - Auto adjust decrements magnitude when result hits zero
// - Averaging code 0 off, else 2..128 samples
// - Every averaged sample fires full emitter burst
// - Average goes to result or moving filter
// - Auto decrement sets the offset changed flag
// - Flag clears on write one or enable off
// - Done bit mirrors calibration interrupt flag
// - Calibration searches offset, then loads offset registers
// - Calibration completion raises calibration interrupt flag
// - Offset is 8-bit magnitude plus sign
package poc_pkg;

    // Register offsets
    localparam logic [7:0] CAL_CFG_ADDR  = 8'hD9;
    localparam logic [7:0] CAL_STAT_ADDR = 8'hDC;
    localparam logic [7:0] OFS_MAG_ADDR  = 8'hC0;
    localparam logic [7:0] OFS_SIGN_ADDR = 8'hC1;

    // Reset values
    localparam logic [7:0] CAL_CFG_RST = 8'h50;
    localparam logic [7:0] OFS_MAG_RST = 8'h00;
    localparam logic       OFS_SIGN_RST = 1'b0;

    // Field positions in calibration_config
    localparam int TGT_MSB  = 7;
    localparam int TGT_LSB  = 5;
    localparam int RSV_BIT  = 4;
    localparam int AUTO_BIT = 3;
    localparam int AVG_MSB  = 2;
    localparam int AVG_LSB  = 0;

    // Field positions in calibration_status
    localparam int CHG_BIT  = 2;
    localparam int DONE_BIT = 0;

    // Widths of the offset, the search code and the target
    localparam int OFS_W  = 8;
    localparam int SRCH_W = 9;
    localparam int TGT_W  = 10;
    localparam logic [8:0] SRCH_MID = 9'h100;

    // Averager and calibration state machines
    typedef enum logic [1:0] {AVG_IDLE, AVG_WAIT} poc_avg_st_t;
    typedef enum logic [1:0] {CAL_IDLE, CAL_TRY, CAL_WAIT, CAL_LOAD}
        poc_cal_st_t;

    // Target code to baseline result: 2^(code+2)-1
    function automatic logic [9:0] targetFor(input logic [2:0] code);
        logic [10:0] t;
        t = (11'h004 << code) - 11'h001;
        return t[9:0];
    endfunction

    // Averaging code to samples per cycle; code 0 is a single sample
    function automatic logic [7:0] samplesFor(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

endpackage

// ### core/poc_avg.sv
// Hardware sample averager for one proximity cycle
`timescale 1ns/1ps
module poc_avg
#(
    parameter int DATA_W = 14
)
(
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  sysRst,
    input  wire logic                  ce,
    // Cycle control
    input  wire logic                  start,
    input  wire logic [2:0]            avgCode,
    // Converter side
    output logic                       burstStart,
    input  wire logic                  sampleValid,
    input  wire logic [DATA_W-1:0]     sampleData,
    // Averaged result
    output logic                       done,
    output logic [DATA_W-1:0]          avgData
);
    import poc_pkg::*;

    localparam int ACC_W = DATA_W + 7;

    // Refuse widths that cannot hold the largest target
    if (DATA_W < TGT_W) begin : g_chk
        $error("poc_avg: DATA_W must be at least 10");
    end

    poc_avg_st_t        state_r;    // Averager state
    logic [2:0]         code_r;     // Code latched per cycle
    logic [7:0]         left_r;     // Samples still to take
    logic [ACC_W-1:0]   acc_r;      // Running sum
    logic [ACC_W-1:0]   accNxt;     // Sum with current sample
    logic [ACC_W-1:0]   accShift;   // Sum divided by count

    // Sum and power-of-two division
    always_comb
    begin
        accNxt   = acc_r + {{7{1'b0}}, sampleData};
        accShift = accNxt >> code_r;
    end

    // Sample collection; a new start is ignored while busy
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            state_r    <= AVG_IDLE;
            code_r     <= 3'h0;
            left_r     <= 8'h00;
            acc_r      <= '0;
            burstStart <= 1'b0;
            done       <= 1'b0;
            avgData    <= '0;
        end
        else if (ce)
        begin
            burstStart <= 1'b0;
            done       <= 1'b0;
            case (state_r)
                AVG_IDLE:
                begin
                    if (start)
                    begin
                        code_r     <= avgCode;
                        left_r     <= samplesFor(avgCode);
                        acc_r      <= '0;
                        burstStart <= 1'b1;
                        state_r    <= AVG_WAIT;
                    end
                end
                AVG_WAIT:
                begin
                    if (sampleValid)
                    begin
                        if (left_r == 8'h01)
                        begin
                            // Last sample: publish the mean
                            avgData <= accShift[DATA_W-1:0];
                            done    <= 1'b1;
                            state_r <= AVG_IDLE;
                        end
                        else
                        begin
                            // Next sample gets its own full burst
                            acc_r      <= accNxt;
                            left_r     <= left_r - 8'h01;
                            burstStart <= 1'b1;
                        end
                    end
                end
                default:
                    state_r <= AVG_IDLE;
            endcase
        end
    end

endmodule

// ### core/poc_cal.sv
// Binary search of the signed offset against the result target
`timescale 1ns/1ps
module poc_cal
#(
    parameter int DATA_W = 14
)
(
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  sysRst,
    input  wire logic                  ce,
    // Control
    input  wire logic                  start,
    input  wire logic [9:0]            target,
    output logic                       busy,
    // Measurement loop
    output logic                       cycleReq,
    input  wire logic                  resultValid,
    input  wire logic [DATA_W-1:0]     result,
    output logic [7:0]                 trialMag,
    output logic                       trialSign,
    // Outcome
    output logic                       done,
    output logic [7:0]                 finalMag,
    output logic                       finalSign
);
    import poc_pkg::*;

    poc_cal_st_t        state_r;    // Search state
    logic [8:0]         code_r;     // Offset plus 256
    logic [8:0]         probe_r;    // Bit under trial
    logic [8:0]         keep;       // Code after this trial

    // Code to sign and magnitude, clamped to 255 each way
    function automatic logic [8:0] toOffset(input logic [8:0] c);
        logic [8:0] m;
        m = 9'h000;
        if (c >= SRCH_MID)
            return {1'b0, c[7:0]};
        m = SRCH_MID - c;
        return (m[8]) ? 9'h1FF : {1'b1, m[7:0]};
    endfunction

    // Result below target means too much offset: drop the bit
    always_comb
    begin
        keep = (result >= DATA_W'(target)) ? code_r : (code_r & ~probe_r);
    end

    assign busy = (state_r != CAL_IDLE);

    // Successive approximation, one proximity cycle per bit
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            state_r   <= CAL_IDLE;
            code_r    <= SRCH_MID;
            probe_r   <= SRCH_MID;
            cycleReq  <= 1'b0;
            trialMag  <= 8'h00;
            trialSign <= 1'b0;
            done      <= 1'b0;
            finalMag  <= 8'h00;
            finalSign <= 1'b0;
        end
        else if (ce)
        begin
            cycleReq <= 1'b0;
            done     <= 1'b0;
            case (state_r)
                CAL_IDLE:
                begin
                    if (start)
                    begin
                        code_r  <= SRCH_MID;
                        probe_r <= SRCH_MID;
                        state_r <= CAL_TRY;
                    end
                end
                CAL_TRY:
                begin
                    // Apply trial offset and measure
                    {trialSign, trialMag} <= toOffset(code_r);
                    cycleReq <= 1'b1;
                    state_r  <= CAL_WAIT;
                end
                CAL_WAIT:
                begin
                    if (resultValid)
                    begin
                        if (probe_r[0])
                        begin
                            code_r  <= keep;
                            state_r <= CAL_LOAD;
                        end
                        else
                        begin
                            code_r  <= keep | (probe_r >> 1);
                            probe_r <= probe_r >> 1;
                            state_r <= CAL_TRY;
                        end
                    end
                end
                CAL_LOAD:
                begin
                    // Closest code found; hand it over
                    {finalSign, finalMag} <= toOffset(code_r);
                    done    <= 1'b1;
                    state_r <= CAL_IDLE;
                end
                default:
                    state_r <= CAL_IDLE;
            endcase
        end
    end

endmodule

// ### core/poc_ctrl.sv
// Offset calibration and averaging control with its registers
`timescale 1ns/1ps
module poc_ctrl
#(
    parameter int DATA_W  = 14,
    parameter int PULSE_W = 6
)
(
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  sysRst,
    input  wire logic                  ce,
    // Register port
    input  wire logic [7:0]            regAddr,
    input  wire logic                  regWrEn,
    input  wire logic [7:0]            regWrData,
    input  wire logic                  regRdEn,
    output logic [7:0]                 regRdData,
    // Proximity cycle and converter
    input  wire logic                  cycleStart,
    input  wire logic [PULSE_W-1:0]    pulseCount,
    output logic                       burstStart,
    output logic [PULSE_W-1:0]         burstLen,
    input  wire logic                  sampleValid,
    input  wire logic [DATA_W-1:0]     sampleData,
    // Calibration
    input  wire logic                  calStart,
    input  wire logic                  calIntFlag,
    output logic                       calIntSet,
    // Offset applied to the front end
    output logic [7:0]                 afeOffsetMag,
    output logic                       afeOffsetSign,
    // Result routing
    input  wire logic [1:0]            movingAvgSel,
    output logic                       filterInValid,
    output logic [DATA_W-1:0]          filterInData,
    input  wire logic                  filteredValid,
    input  wire logic [DATA_W-1:0]     filteredData,
    output logic                       proxResultValid,
    output logic [DATA_W-1:0]          proxResult
);
    import poc_pkg::*;

    // Refuse settings the logic cannot serve
    if (DATA_W < TGT_W || DATA_W > 24) begin : g_chk_data
        $error("poc_ctrl: DATA_W must lie in 10..24");
    end
    if (PULSE_W < 1) begin : g_chk_pulse
        $error("poc_ctrl: PULSE_W must be positive");
    end

    logic [7:0]         cfg_r;          // calibration_config
    logic               chgFlag_r;      // offset_changed_flag
    logic [7:0]         offsetMag_r;    // offset_magnitude
    logic               offsetSign_r;   // offset_sign
    logic [9:0]         calTarget;      // Decoded search target
    logic               autoEn;         // auto_offset_decrement_en
    logic [2:0]         avgCount;       // sample_average_count code

    logic               avgStart;       // Cycle start to averager
    logic               avgDone;        // Averaged value ready
    logic [DATA_W-1:0]  avgData;        // Averaged value
    logic               calBusy;        // Search in progress
    logic               calCycleReq;    // Search wants a cycle
    logic               calDone;        // Search finished
    logic [7:0]         trialMag;       // Offset under trial
    logic               trialSign;
    logic [7:0]         finalMag;       // Offset found
    logic               finalSign;

    logic               cfgWr;          // Host writes config
    logic               statWr;         // Host writes status
    logic               magWr;          // Host writes magnitude
    logic               signWr;         // Host writes sign
    logic               pdataWrite;     // Result register updates
    logic [DATA_W-1:0]  pdataNew;       // Value it takes
    logic               decNow;         // Zero result seen, enabled
    logic               decApply;       // Decrement really happens
    logic [7:0]         readVal;        // Read mux

    // Field decode
    always_comb
    begin
        calTarget = targetFor(cfg_r[TGT_MSB:TGT_LSB]);
        autoEn    = cfg_r[AUTO_BIT];
        avgCount  = cfg_r[AVG_MSB:AVG_LSB];
    end

    // Write strobes per register
    always_comb
    begin
        cfgWr  = regWrEn && (regAddr == CAL_CFG_ADDR);
        statWr = regWrEn && (regAddr == CAL_STAT_ADDR);
        magWr  = regWrEn && (regAddr == OFS_MAG_ADDR);
        signWr = regWrEn && (regAddr == OFS_SIGN_ADDR);
    end

    // Calibration owns the cycle trigger while it runs
    always_comb
    begin
        avgStart = calBusy ? calCycleReq : cycleStart;
    end

    // Averager
    poc_avg #(
        .DATA_W      (DATA_W)
    ) u_avg (
        .clk         (clk),
        .sysRst      (sysRst),
        .ce          (ce),
        .start       (avgStart),
        .avgCode     (avgCount),
        .burstStart  (burstStart),
        .sampleValid (sampleValid),
        .sampleData  (sampleData),
        .done        (avgDone),
        .avgData     (avgData)
    );

    // Offset search
    poc_cal #(
        .DATA_W      (DATA_W)
    ) u_cal (
        .clk         (clk),
        .sysRst      (sysRst),
        .ce          (ce),
        .start       (calStart),
        .target      (calTarget),
        .busy        (calBusy),
        .cycleReq    (calCycleReq),
        .resultValid (avgDone && calBusy),
        .result      (avgData),
        .trialMag    (trialMag),
        .trialSign   (trialSign),
        .done        (calDone),
        .finalMag    (finalMag),
        .finalSign   (finalSign)
    );

    // Result register update: direct average or filter output
    always_comb
    begin
        if (avgDone && !calBusy && movingAvgSel == 2'b00)
        begin
            pdataWrite = 1'b1;
            pdataNew   = avgData;
        end
        else
        begin
            pdataWrite = filteredValid;
            pdataNew   = filteredData;
        end
        decNow   = pdataWrite && (pdataNew == '0) && autoEn;
        decApply = decNow && (offsetMag_r != 8'h00) && !calDone && !magWr;
    end

    // Configuration register, written as given
    always_ff @(posedge clk)
    begin
        if (sysRst)
            cfg_r <= CAL_CFG_RST;
        else if (ce && cfgWr)
            cfg_r <= regWrData;
    end

    // Offset magnitude: load, host write, then auto decrement
    always_ff @(posedge clk)
    begin
        if (sysRst)
            offsetMag_r <= OFS_MAG_RST;
        else if (ce)
        begin
            if (calDone)
                offsetMag_r <= finalMag;
            else if (magWr)
                offsetMag_r <= regWrData;
            else if (decApply)
                offsetMag_r <= offsetMag_r - 8'h01;
        end
    end

    // Offset sign
    always_ff @(posedge clk)
    begin
        if (sysRst)
            offsetSign_r <= OFS_SIGN_RST;
        else if (ce)
        begin
            if (calDone)
                offsetSign_r <= finalSign;
            else if (signWr)
                offsetSign_r <= regWrData[0];
        end
    end

    // Changed flag: set beats either clear
    always_ff @(posedge clk)
    begin
        if (sysRst)
            chgFlag_r <= 1'b0;
        else if (ce)
        begin
            if (decApply)
                chgFlag_r <= 1'b1;
            else if ((statWr && regWrData[CHG_BIT]) ||
                     (cfgWr && !regWrData[AUTO_BIT]))
                chgFlag_r <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        case (regAddr)
            CAL_CFG_ADDR:  readVal = cfg_r;
            CAL_STAT_ADDR:
            begin
                readVal = 8'h00;
                readVal[CHG_BIT]  = chgFlag_r;
                readVal[DONE_BIT] = calIntFlag;
            end
            OFS_MAG_ADDR:  readVal = offsetMag_r;
            OFS_SIGN_ADDR: readVal = {7'h00, offsetSign_r};
            default:       readVal = 8'h00;
        endcase
    end

    // Read data register
    always_ff @(posedge clk)
    begin
        if (sysRst)
            regRdData <= 8'h00;
        else if (ce && regRdEn)
            regRdData <= readVal;
    end

    // Burst length latched at each averager start, including one the busy averager ignores
    always_ff @(posedge clk)
    begin
        if (sysRst)
            burstLen <= '0;
        else if (ce && avgStart)
            burstLen <= pulseCount;
    end

    // Calibration interrupt request
    always_ff @(posedge clk)
    begin
        if (sysRst)
            calIntSet <= 1'b0;
        else if (ce)
            calIntSet <= calDone;
    end

    // Offset driven to the front end
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            afeOffsetMag  <= OFS_MAG_RST;
            afeOffsetSign <= OFS_SIGN_RST;
        end
        else if (ce)
        begin
            afeOffsetMag  <= calBusy ? trialMag : offsetMag_r;
            afeOffsetSign <= calBusy ? trialSign : offsetSign_r;
        end
    end

    // Average routing and result register
    always_ff @(posedge clk)
    begin
        if (sysRst)
        begin
            filterInValid   <= 1'b0;
            filterInData    <= '0;
            proxResultValid <= 1'b0;
            proxResult      <= '0;
        end
        else if (ce)
        begin
            filterInValid   <= 1'b0;
            proxResultValid <= pdataWrite;
            if (pdataWrite)
                proxResult <= pdataNew;
            if (avgDone && !calBusy && movingAvgSel != 2'b00)
            begin
                filterInValid <= 1'b1;
                filterInData  <= avgData;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sysRst);

    sequence s_dec;
        ce && decApply;
    endsequence

    sequence s_direct;
        ce && avgDone && !calBusy && movingAvgSel == 2'b00;
    endsequence

    a_cfg_reset: assert property (
        $past(sysRst) |-> cfg_r == CAL_CFG_RST)
        else $error("config reset value wrong");

    a_target_two: assert property (
        cfg_r[TGT_MSB:TGT_LSB] == 3'h2 |-> calTarget == 10'd15)
        else $error("target code 2 not 15");

    a_auto_dec: assert property (
        s_dec |=> offsetMag_r == $past(offsetMag_r) - 8'h01)
        else $error("magnitude not decremented");

    a_no_wrap: assert property (
        ce && offsetMag_r == 8'h00 && !magWr && !calDone
        |=> offsetMag_r == 8'h00)
        else $error("magnitude wrapped");

    a_flag_set: assert property (
        s_dec |=> chgFlag_r)
        else $error("changed flag not set");

    a_flag_clear: assert property (
        ce && !decApply && statWr && regWrData[CHG_BIT] |=> !chgFlag_r)
        else $error("changed flag not cleared");

    a_done_mirror: assert property (
        ce && regRdEn && regAddr == CAL_STAT_ADDR
        |=> regRdData[DONE_BIT] == $past(calIntFlag))
        else $error("done bit not mirrored");

    a_direct_route: assert property (
        s_direct |=> proxResultValid && proxResult == $past(avgData)
                     && !filterInValid)
        else $error("direct result not routed");

    a_cal_finish: assert property (
        ce && calDone |=> calIntSet && offsetMag_r == $past(finalMag))
        else $error("calibration result not loaded");

    a_cal_irq: assert property (
        ce && calStart && !calBusy |-> ##[1:900] calIntSet)
        else $error("calibration never finished");

endmodule

// ### sim/poc_conv_model.sv
// Converter model: returns one sample per emitter burst
`timescale 1ns/1ps
module poc_conv_model
(
    // Clock and burst request
    input  wire logic        clk,
    input  wire logic        burstStart,
    // Value the front end would convert
    input  wire logic [13:0] level,
    // Sample output and burst tally
    output logic             sampleValid = 1'h0,
    output logic [13:0]      sampleData = 14'h0000,
    output int               burstCnt = 0
);
    logic pend = 1'h0; // Burst in flight

    // Answer two edges after each burst; data toggles while idle
    always @(posedge clk)
    begin
        pend <= burstStart;
        sampleValid <= pend;
        sampleData <= pend ? level : ~sampleData;
        burstCnt <= burstCnt + int'(burstStart);
    end
endmodule

// ### sim/poc_ctrl_tb_top.sv
// Testbench for offset calibration and averaging control
`timescale 1ns/1ps
module poc_ctrl_tb_top;
    import poc_pkg::*;
    logic        clk = 1'h0, sysRst = 1'h1, wrEn = 1'h0, rdEn = 1'h0;
    logic        cycStart = 1'h0, calStart = 1'h0, calIntFlag = 1'h0;
    logic        zeroIn = 1'h0, burstStart, sampleValid, calIntSet;
    logic        resValid, filtValid, afeSign, fltValid = 1'h0, ce = 1'h1;
    logic [1:0]  avgSel = 2'h0;
    logic [5:0]  burstLen;
    logic [7:0]  addr = 8'h00, wrData = 8'h00, rdData, afeMag;
    logic [13:0] sampleData, result, level, filtData, fltData = 14'h0000;
    int          error_cnt = 0, cmp_count = 0, burstCnt, ofs;

    // Clock
    always #12.5 clk = ~clk;

    // Front end: result falls as offset rises, floor at zero
    always_comb
    begin
        ofs = afeSign ? -int'(afeMag) : int'(afeMag);
        level = (zeroIn || ofs > 200) ? 14'h0000 : 14'(200 - ofs);
    end

    // Filter stand-in: hands each average back one cycle later
    always @(negedge clk)
    begin
        fltValid <= filtValid;
        fltData  <= filtData;
    end

    poc_ctrl dut_u
    (
        .clk(clk), .sysRst(sysRst), .ce(ce), .regAddr(addr),
        .regWrEn(wrEn), .regWrData(wrData), .regRdEn(rdEn),
        .regRdData(rdData), .cycleStart(cycStart), .pulseCount(6'h05),
        .burstStart(burstStart), .burstLen(burstLen),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .calStart(calStart), .calIntFlag(calIntFlag),
        .calIntSet(calIntSet), .afeOffsetMag(afeMag),
        .afeOffsetSign(afeSign), .movingAvgSel(avgSel),
        .filterInValid(filtValid), .filterInData(filtData),
        .filteredValid(fltValid), .filteredData(fltData),
        .proxResultValid(resValid),
        .proxResult(result)
    );

    poc_conv_model conv_u
    (
        .clk(clk), .burstStart(burstStart), .level(level),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .burstCnt(burstCnt)
    );

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wrData = d;
        wrEn = 1'h1;
        @(negedge clk);
        wrEn = 1'h0;
    endtask

    // Register read, checked once the data is registered
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rdEn = 1'h1;
        @(negedge clk);
        rdEn = 1'h0;
        @(negedge clk);
        chk(16'(rdData), 16'(exp));
    endtask

    // One proximity cycle: count bursts, check the routed value
    task automatic proxCycle(input int n, input logic [13:0] exp);
        int b;
        b = burstCnt;
        @(negedge clk);
        cycStart = 1'h1;
        @(negedge clk);
        cycStart = 1'h0;
        for (int i = 0; i < 2000 && !(resValid | filtValid); i++)
            @(negedge clk);
        chk(16'(resValid | filtValid), 16'h0001);
        chk(16'(burstCnt - b), 16'(n));
        chk(16'(burstLen), 16'h0005);
        chk(16'(filtValid), 16'(avgSel != 2'h0));
        if (avgSel == 2'h0)
            chk(16'(result), 16'(exp));
        else
        begin
            chk(16'(filtData), 16'(exp));
            @(negedge clk);
            chk(16'(resValid), 16'h0001);
            chk(16'(result), 16'(exp));
        end
    endtask

    // Calibrate; search ends where the result just meets the target
    task automatic calib(input logic [2:0] code);
        int o, m;
        o = 200 - ((4 << code) - 1);
        m = (o < -255) ? 255 : ((o < 0) ? -o : o);
        wr(CAL_CFG_ADDR, {code, 5'h10});
        @(negedge clk);
        calStart = 1'h1;
        @(negedge clk);
        calStart = 1'h0;
        for (int i = 0; i < 5000 && calIntSet !== 1'h1; i++)
            @(negedge clk);
        chk(16'(calIntSet), 16'h0001);
        calIntFlag = 1'h1;
        rd(OFS_MAG_ADDR, 8'(m));
        rd(OFS_SIGN_ADDR, {7'h00, o < 0});
        rd(CAL_STAT_ADDR, 8'h01);
        calIntFlag = 1'h0;
        rd(CAL_STAT_ADDR, 8'h00);
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(negedge clk);
        sysRst = 1'h0;
        rd(CAL_CFG_ADDR, 8'h50);
        rd(CAL_STAT_ADDR, 8'h00);
        rd(OFS_MAG_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            wr(CAL_CFG_ADDR, 8'h50 | 8'(k));
            proxCycle(1 << k, 14'h00C8);
        end
        avgSel = 2'h1;
        proxCycle(128, 14'h00C8);
        avgSel = 2'h0;
        for (int c = 0; c < 8; c++)
            calib(3'(c));
        wr(OFS_SIGN_ADDR, 8'h00);
        wr(OFS_MAG_ADDR, 8'h02);
        wr(CAL_CFG_ADDR, 8'h58);
        zeroIn = 1'h1;
        proxCycle(1, 14'h0000);
        rd(OFS_MAG_ADDR, 8'h01);
        rd(CAL_STAT_ADDR, 8'h04);
        wr(CAL_STAT_ADDR, 8'h04);
        rd(CAL_STAT_ADDR, 8'h00);
        proxCycle(1, 14'h0000);
        proxCycle(1, 14'h0000);
        rd(OFS_MAG_ADDR, 8'h00);
        rd(CAL_STAT_ADDR, 8'h04);
        wr(CAL_CFG_ADDR, 8'h50);
        rd(CAL_STAT_ADDR, 8'h00);
        ce = 1'h0;
        wr(CAL_CFG_ADDR, 8'h5F);
        ce = 1'h1;
        rd(CAL_CFG_ADDR, 8'h50);
        end_of_test();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #(25 * 20000);
        error_cnt++;
        end_of_test();
    end
endmodule
